// ==== design/memory_map_decoder.sv ====
// memory_map_decoder.sv: two-level address decoder with boot aliasing
// assumes: masters hold one request per cycle; option store on i_nv_stored
// ====================================================================
`timescale 1ns/10ps
`default_nettype none
`include "memory_map_decoder_params.svh"
module memory_map_decoder
	import memory_map_decoder_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input var req_t i_req,
	input var opt_cmd_t i_opt_cmd,
	input wire logic i_remap_cmd,
	input wire logic i_wipe,
	input wire logic [`OPT_BITS-1:0] i_nv_stored,
	input wire logic [`WBUF_IDX_BITS-1:0] i_wbuf_raddr,
	output var sel_t o_sel,
	output var flash_loc_t o_flash_loc,
	output logic [31:0] o_wbuf_rdata,
	output logic [`OPT_BITS-1:0] o_opt_bits,
	output logic o_remap,
	output logic o_boot_flash,
	output logic o_ready
);
	// ================================================================
	// reset release
	logic rst_meta_reg;
	logic rst_n;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// ================================================================
	// pin synchronisers, three stages with agreement filter
	logic [`OPT_BITS:0] pin_s1_reg;
	logic [`OPT_BITS:0] pin_s2_reg;
	logic [`OPT_BITS:0] pin_s3_reg;
	logic [`OPT_BITS:0] pin_filt_reg;
	logic [`OPT_BITS:0] pin_filt_next;
	logic wipe_f;
	logic [`OPT_BITS-1:0] nv_f;
	assign wipe_f = pin_filt_reg[`OPT_BITS];
	assign nv_f = pin_filt_reg[`OPT_BITS-1:0];
	always_comb begin
		for (int k = 0; k <= `OPT_BITS; k++) begin
			pin_filt_next[k] = (pin_s2_reg[k] == pin_s3_reg[k]) ?
				pin_s3_reg[k] : pin_filt_reg[k];
		end
	end
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			pin_s3_reg <= '0;
			pin_filt_reg <= '0;
		end else begin
			pin_s1_reg <= {i_wipe, i_nv_stored};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			pin_filt_reg <= pin_filt_next;
		end
	end

	// ================================================================
	// start-up sequence
	init_state_t state_reg;
	init_state_t state_next;
	logic [1:0] wait_reg;
	logic [1:0] wait_next;
	always_comb begin
		state_next = state_reg;
		wait_next = wait_reg;
		case (state_reg)
		ST_WAIT: begin
			wait_next = wait_reg + 2'h1;
			if (wait_reg == `INIT_WAIT_CYCLES) begin
				state_next = ST_LOAD;
			end
		end
		ST_LOAD: begin
			state_next = ST_RUN;
		end
		default: begin
			state_next = ST_RUN;
		end
		endcase
	end
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_WAIT;
			wait_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			wait_reg <= wait_next;
		end
	end
	wire running = (state_reg == ST_RUN);
	wire loading = (state_reg == ST_LOAD);

	// ================================================================
	// option bits, remap and boot alias
	logic [`OPT_BITS-1:0] opt_reg;
	logic [`OPT_BITS-1:0] opt_next;
	logic [`OPT_BITS-1:0] cmd_mask;
	logic remap_reg;
	logic boot_flash_reg;
	assign cmd_mask = `OPT_BITS'(1) << i_opt_cmd.index;
	always_comb begin
		opt_next = opt_reg;
		if (loading) begin
			opt_next = nv_f;
		end else if (running && wipe_f) begin
			opt_next[`OPT_BOOT_BIT] = 1'b0;
		end else if (running && i_opt_cmd.set) begin
			opt_next = opt_reg | cmd_mask;
		end else if (running && i_opt_cmd.clear) begin
			opt_next = opt_reg & ~cmd_mask;
		end
	end
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			opt_reg <= `OPT_RESET;
			remap_reg <= 1'b0;
			boot_flash_reg <= 1'b0;
		end else begin
			opt_reg <= opt_next;
			if (running && i_remap_cmd) begin
				remap_reg <= 1'b1;
			end
			if (loading) begin
				boot_flash_reg <= nv_f[`OPT_BOOT_BIT];
			end
		end
	end

	// ================================================================
	// address decode
	wire [3:0] area = i_req.addr[`AREA_MSB:`AREA_LSB];
	wire [7:0] region = i_req.addr[`REGION_MSB:`REGION_LSB];
	wire go = running && i_req.valid;
	wire in_int = (area == `AREA_INTERNAL);
	wire in_ext = (area >= `AREA_EXT_FIRST) && (area <= `AREA_EXT_LAST);
	wire in_apb = (area == `AREA_PERIPH);
	wire r_zero = in_int && (region == `REGION_ZERO);
	wire hit_flash = (in_int && (region == `REGION_FLASH)) ||
		(r_zero && !remap_reg && boot_flash_reg);
	wire hit_sram = (in_int && (region == `REGION_SRAM)) ||
		(r_zero && remap_reg);
	wire hit_rom = (in_int && (region == `REGION_ROM)) ||
		(r_zero && !remap_reg && !boot_flash_reg);
	wire hit_int = hit_flash || hit_sram || hit_rom;
	wire [2:0] ext_idx = 3'(area - `AREA_EXT_FIRST);
	wire [`EXT_SELECTS-1:0] ext_dec = in_ext ?
		(`EXT_SELECTS'(1) << ext_idx) : '0;
	wire is_abort = !(in_ext || in_apb || hit_int);
	sel_t sel_next;
	assign sel_next = '{valid: go, abort: go && is_abort,
		ext_cs: go ? ext_dec : '0, apb: go && in_apb,
		flash: go && hit_flash, sram: go && hit_sram,
		rom: go && hit_rom,
		offset: i_req.addr[`OFFSET_BITS-1:0]};
	flash_loc_t loc_next;
	assign loc_next = '{bank: i_req.addr[`FLASH_BANK_BIT],
		page: i_req.addr[`FLASH_PAGE_MSB:`FLASH_PAGE_LSB],
		word: i_req.addr[`FLASH_BANK_BIT:2]};

	// ================================================================
	// flash write buffer, one page of words
	logic [31:0] wbuf_mem [`WBUF_WORDS];
	wire [`WBUF_IDX_BITS-1:0] wbuf_widx = i_req.addr[7:2];
	wire wbuf_we = go && hit_flash && i_req.write;
	always_ff @(posedge i_clk) begin
		if (wbuf_we) begin
			wbuf_mem[wbuf_widx] <= i_req.wdata;
		end
	end

	// ================================================================
	// registered outputs
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_sel <= '0;
			o_flash_loc <= '0;
			o_wbuf_rdata <= 32'h0000_0000;
			o_opt_bits <= `OPT_RESET;
			o_remap <= 1'b0;
			o_boot_flash <= 1'b0;
			o_ready <= 1'b0;
		end else begin
			o_sel <= sel_next;
			o_flash_loc <= loc_next;
			o_wbuf_rdata <= wbuf_mem[i_wbuf_raddr];
			o_opt_bits <= opt_reg;
			o_remap <= remap_reg;
			o_boot_flash <= boot_flash_reg;
			o_ready <= running;
		end
	end

	// ================================================================
	// assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_n);
	logic [31:0] a_addr_reg;
	logic a_go_reg;
	wire [31:0] a_addr = a_addr_reg;
	wire a_go = a_go_reg;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			a_addr_reg <= 32'h0000_0000;
			a_go_reg <= 1'b0;
		end else begin
			a_addr_reg <= i_req.addr;
			a_go_reg <= go;
		end
	end
	ext_select_a: assert property (
		a_go && $past(in_ext) |->
		o_sel.ext_cs == (8'h01 << (a_addr[31:28] - 4'h1)))
		else $error("external select does not follow area");
	periph_route_a: assert property (
		o_sel.apb |-> a_go && a_addr[31:28] == 4'hf && !o_sel.abort)
		else $error("peripheral select outside area fifteen");
	unmapped_abort_a: assert property (
		a_go && a_addr[31:28] > 4'h8 && a_addr[31:28] < 4'hf
		|-> o_sel.abort && o_sel.ext_cs == 8'h00)
		else $error("unmapped area not aborted");
	sram_zero_a: assert property (
		a_go && a_addr[31:20] == 12'h000 && !$past(remap_reg)
		|-> !o_sel.sram)
		else $error("sram answered at zero before remap");
	sram_remap_a: assert property (
		a_go && $past(remap_reg) &&
		(a_addr[31:20] == 12'h000 || a_addr[31:20] == 12'h002)
		|-> o_sel.sram)
		else $error("sram missing after remap");
	rom_fixed_a: assert property (
		a_go && a_addr[31:20] == 12'h003 |-> o_sel.rom)
		else $error("rom not at fixed base");
	flash_fixed_a: assert property (
		a_go && a_addr[31:20] == 12'h001 |-> o_sel.flash)
		else $error("flash not at fixed base");
	boot_alias_a: assert property (
		a_go && a_addr[31:20] == 12'h000 && !$past(remap_reg)
		|-> o_sel.flash == $past(boot_flash_reg) &&
		o_sel.rom == !$past(boot_flash_reg))
		else $error("address zero alias wrong");
	wipe_clear_a: assert property (
		running && wipe_f |=> !opt_reg[2])
		else $error("wipe did not clear boot bit");
	opt_stable_a: assert property (
		running && $past(running) && !i_opt_cmd.set &&
		!i_opt_cmd.clear && !wipe_f |=> $stable(opt_reg))
		else $error("option bits changed without command");
	high_abort_a: assert property (
		a_go && a_addr[31:28] == 4'h0 && a_addr[27:22] != 6'h00
		|-> o_sel.abort)
		else $error("internal hole not aborted");
	remap_hold_a: assert property (
		remap_reg |=> remap_reg [*4])
		else $error("remap dropped before reset");
	alias_hold_a: assert property (
		running && $past(running) |-> $stable(boot_flash_reg))
		else $error("boot alias moved after start-up");
	wbuf_load_a: assert property (
		wbuf_we ##1 (i_wbuf_raddr == $past(wbuf_widx)) && !wbuf_we
		|=> o_wbuf_rdata == $past(i_req.wdata, 2))
		else $error("write buffer word lost");
	cs_onehot_a: assert property (
		o_sel.valid |-> $onehot0(o_sel.ext_cs))
		else $error("more than one external select");
	one_target_a: assert property (
		o_sel.valid |-> $onehot({o_sel.abort, |o_sel.ext_cs, o_sel.apb,
		o_sel.flash, o_sel.sram, o_sel.rom}))
		else $error("request routed to no target or several");
	ext_cover_c: cover property (o_sel.ext_cs[7]);
	remap_cover_c: cover property (remap_reg && o_sel.sram);
	flash_boot_c: cover property (o_sel.flash && boot_flash_reg);
	abort_cover_c: cover property (o_sel.abort);
	wipe_cover_c: cover property (running && wipe_f);
endmodule
`default_nettype wire

// ==== design/memory_map_decoder_params.svh ====
// memory_map_decoder_params.svh: address map, field positions, counts
// assumes: included by the package and the decoder after the package
`ifndef MEMORY_MAP_DECODER_PARAMS_SVH
`define MEMORY_MAP_DECODER_PARAMS_SVH

// ====================================================================
// first level: sixteen areas of 256 Mbytes
`define AREA_MSB 31
`define AREA_LSB 28
`define AREA_INTERNAL 4'h0
`define AREA_EXT_FIRST 4'h1
`define AREA_EXT_LAST 4'h8
`define AREA_PERIPH 4'hf
`define EXT_SELECTS 8

// ====================================================================
// second level: 1 Mbyte regions inside area zero
`define REGION_MSB 27
`define REGION_LSB 20
`define REGION_ZERO 8'h00
`define REGION_FLASH 8'h01
`define REGION_SRAM 8'h02
`define REGION_ROM 8'h03
`define OFFSET_BITS 20

// ====================================================================
// flash geometry and write buffer
`define FLASH_BANKS 2
`define FLASH_PAGES_PER_BANK 1024
`define FLASH_PAGE_BYTES 256
`define FLASH_WORDS 131072
`define FLASH_WORD_BITS 17
`define FLASH_BANK_BIT 18
`define FLASH_PAGE_MSB 17
`define FLASH_PAGE_LSB 8
`define WBUF_WORDS 64
`define WBUF_IDX_BITS 6

// ====================================================================
// option bits and start-up
`define OPT_BITS 3
`define OPT_BOOT_BIT 2
`define OPT_RESET 3'h0
`define INIT_WAIT_CYCLES 2'h3
`endif

// ==== design/memory_map_decoder_pkg.sv ====
// memory_map_decoder_pkg.sv: request, answer and command types
// assumes: the params header sits beside it
`include "memory_map_decoder_params.svh"
package memory_map_decoder_pkg;
	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} req_t;
	typedef struct packed {
		logic valid;
		logic abort;
		logic [`EXT_SELECTS-1:0] ext_cs;
		logic apb;
		logic flash;
		logic sram;
		logic rom;
		logic [`OFFSET_BITS-1:0] offset;
	} sel_t;
	typedef struct packed {
		logic set;
		logic clear;
		logic [1:0] index;
	} opt_cmd_t;
	typedef struct packed {
		logic bank;
		logic [9:0] page;
		logic [`FLASH_WORD_BITS-1:0] word;
	} flash_loc_t;
	typedef enum logic [1:0] {
		ST_WAIT = 2'b00,
		ST_LOAD = 2'b01,
		ST_RUN = 2'b11
	} init_state_t;
endpackage

// ==== verif/bus_master_model.sv ====
// bus_master_model.sv: single master issuing one request at a time
// assumes: decoder samples the request on the rising edge
`timescale 1ns/10ps
`default_nettype none
module bus_master_model
	import memory_map_decoder_pkg::*;
(
	input wire logic i_clk,
	output var req_t o_req
);
	// ==================================================================
	// request driver
	initial o_req = '0;
	// valid for exactly one edge, then the bus shows inverted junk
	task automatic issue(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		@(negedge i_clk);
		o_req = '{1'b1, w, a, d};
		@(posedge i_clk);
		@(negedge i_clk);
		o_req = '{1'b0, 1'b0, ~a, ~d};
	endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// tb_top.sv: self-checking bench for the address decoder
// assumes: package compiled first, master model beside it
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %0t: got %0h exp %0h", $time, g, e); end end
module tb_top;
	import memory_map_decoder_pkg::*;
	// ==================================================================
	// signals
	logic clk = 1'b0, rst_n = 1'b0, rcmd = 1'b0, wipe = 1'b0;
	logic rmp = 1'b0, bf = 1'b0, remap, bootf, ready;
	logic [2:0] nv = 3'h0, opt;
	logic [5:0] raddr = 6'h00;
	logic [31:0] wbuf;
	opt_cmd_t cmd = '0;
	req_t req;
	sel_t sel;
	flash_loc_t loc;
	int fails = 0, n_compared = 0;
	localparam logic [31:0] tab [8] = '{32'h0000_0004, 32'h0010_0000,
		32'h001f_fffc, 32'h0020_0010, 32'h0030_0000, 32'h003f_fffc,
		32'h0040_0000, 32'h0fff_fffc};
	initial forever #12.5 clk = ~clk;
	bus_master_model m (.i_clk(clk), .o_req(req));
	memory_map_decoder uut (.i_clk(clk), .i_rst_n(rst_n), .i_req(req),
		.i_opt_cmd(cmd), .i_remap_cmd(rcmd), .i_wipe(wipe),
		.i_nv_stored(nv), .i_wbuf_raddr(raddr), .o_sel(sel),
		.o_flash_loc(loc), .o_wbuf_rdata(wbuf), .o_opt_bits(opt),
		.o_remap(remap), .o_boot_flash(bootf), .o_ready(ready));
	// ==================================================================
	// expected decode
	function automatic sel_t exp_sel(input logic [31:0] a);
		sel_t s;
		s = '0;
		s.valid = 1'b1;
		s.offset = a[19:0];
		if (a[31:28] >= 4'h1 && a[31:28] <= 4'h8) begin
			s.ext_cs[a[31:28] - 4'h1] = 1'b1;
		end else if (a[31:28] == 4'hf) begin
			s.apb = 1'b1;
		end else if (a[31:28] != 4'h0 || a[27:20] > 8'h03) begin
			s.abort = 1'b1;
		end else begin
			case (a[21:20])
				2'h0: {s.sram, s.flash, s.rom} = rmp ? 3'b100 : {1'b0, bf, ~bf};
				2'h1: s.flash = 1'b1;
				2'h2: s.sram = 1'b1;
				default: s.rom = 1'b1;
			endcase
		end
		return s;
	endfunction
	// ==================================================================
	// scenarios
	task automatic do_reset(input logic [2:0] v);
		@(negedge clk);
		rst_n = 1'b0;
		nv = v;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		rmp = 1'b0;
		bf = v[2];
		for (int k = 0; k < 40 && ready !== 1'b1; k++) @(negedge clk);
		`CHK(ready, 1'b1)
		`CHK(bootf, v[2])
		`CHK(opt, v)
		`CHK(remap, 1'b0)
		$display("test reset done");
	endtask
	task automatic t_map();
		logic [31:0] a;
		for (int i = 0; i < 24; i++) begin
			a = (i < 16) ? {i[3:0], 28'h0345678} : tab[i - 16];
			m.issue(1'b0, a, 32'h0);
			`CHK(sel, exp_sel(a))
		end
		$display("test map done");
	endtask
	task automatic t_flash();
		m.issue(1'b1, 32'h0014_7a5c, 32'hc0de_1234);
		`CHK(loc, {1'b1, 10'h07a, 17'h11e97})
		raddr = 6'h17;
		@(negedge clk);
		`CHK(wbuf, 32'hc0de_1234)
		$display("test flash done");
	endtask
	task automatic opt_cmd(input logic s, input logic c,
		input logic [1:0] x);
		@(negedge clk);
		cmd = '{s, c, x};
		@(negedge clk);
		cmd = '0;
		repeat (2) @(negedge clk);
	endtask
	task automatic t_opt();
		logic [2:0] o;
		o = opt;
		opt_cmd(1'b1, 1'b0, 2'h2);
		`CHK(opt, o | 3'h4)
		`CHK(bootf, bf)
		opt_cmd(1'b1, 1'b0, 2'h1);
		opt_cmd(1'b0, 1'b1, 2'h2);
		`CHK(opt, o | 3'h2)
		opt_cmd(1'b1, 1'b1, 2'h2);
		`CHK(opt, o | 3'h6)
		wipe = 1'b1;
		for (int k = 0; k < 20 && opt[2] !== 1'b0; k++) @(negedge clk);
		`CHK(opt, o | 3'h2)
		wipe = 1'b0;
		$display("test option done");
	endtask
	task automatic t_remap();
		logic [2:0] o;
		o = opt;
		@(negedge clk);
		rcmd = 1'b1;
		@(negedge clk);
		rcmd = 1'b0;
		`CHK(remap, 1'b0)
		@(negedge clk);
		`CHK(remap, 1'b1)
		`CHK(opt, o)
		rmp = 1'b1;
		$display("test remap done");
	endtask
	// ==================================================================
	// run control
	task automatic test_done();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		do_reset(3'h0);
		t_map();
		t_flash();
		t_opt();
		t_map();
		t_remap();
		t_map();
		do_reset(3'h4);
		t_map();
		t_flash();
		t_remap();
		t_map();
		test_done();
	end
	initial begin
		#(25 * 4000);
		fails++;
		test_done();
	end
endmodule
`default_nettype wire
